// ---- shared/cdcrm_pkg.sv ----
package cdcrm_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int NUM_STAGES = 12;
  localparam int CFG_PER_STAGE = 8;
  localparam int RES_PER_STAGE = 36;
  // Bank 1 map
  localparam logic [9:0] SETUP_CONTROL = 10'h000;
  localparam logic [9:0] CAL_SETUP = 10'h001;
  localparam logic [9:0] INT_CFG_FIRST = 10'h005;
  localparam logic [9:0] INT_CFG_LAST = 10'h007;
  localparam logic [9:0] LIMIT_STATUS_0 = 10'h008;
  localparam logic [9:0] LIMIT_STATUS_1 = 10'h009;
  localparam logic [9:0] CONVERSION_COMPLETION_STATUS = 10'h00A;
  localparam logic [9:0] RAW_DATA_BASE = 10'h00B;
  localparam logic [9:0] PART_IDENTIFICATION = 10'h017;
  localparam logic [9:0] INVALID_GAP_START = 10'h018;
  localparam logic [9:0] PROXIMITY_STATUS = 10'h042;
  localparam logic [9:0] LOW_POWER_SETTLING_TIME = 10'h045;
  // Bank 2 and 3 bases
  localparam logic [9:0] STAGE_CFG_BASE = 10'h080;
  localparam logic [9:0] STAGE1_CFG = 10'h088;
  localparam logic [9:0] STAGE_RES_BASE = 10'h0E0;
  localparam logic [9:0] STAGE_RES_END = 10'h28F;
  localparam logic [11:0] CAL_EN_MASK = 12'hFFF;
  localparam int CAL_EN_LSB = 0;
  localparam int VALID_INTS = 3;
  // Identity value, arbitrary
  localparam logic [15:0] PART_ID_VALUE = 16'h5A01;
  // Host control register map (word index on the host port)
  localparam logic [3:0] H_CTRL = 4'h0;
  localparam logic [3:0] H_ADDR = 4'h1;
  localparam logic [3:0] H_WDATA = 4'h2;
  localparam logic [3:0] H_RDATA = 4'h3;
  localparam logic [3:0] H_STATUS = 4'h4;
  localparam logic [3:0] H_IRQ_STAT = 4'h5;
  localparam logic [3:0] H_IRQ_MASK = 4'h6;
  localparam int CTRL_WR_BIT = 0;
  localparam int CTRL_RD_BIT = 1;
  localparam int CTRL_SEQ_DONE_BIT = 2;
  localparam int IRQ_XFER_BIT = 0;
  localparam int IRQ_DEVINT_BIT = 1;
  localparam int IRQ_VALID_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
endpackage

// ---- shared/cdcrm_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface cdcrm_if;
  import cdcrm_pkg::*;
  // Serial register word transfer, two bytes packed per word
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic ack;
  logic [DATA_W-1:0] rdata;
  logic dev_int;
  modport device (input req, wr, addr, wdata, output ack, rdata, dev_int);
  modport host (output req, wr, addr, wdata, input ack, rdata, dev_int);
endinterface
`default_nettype wire

// ---- rtl/cdcrm_device.sv ----
// Function
// (RL1) Host loads stage configuration bank first
// (RL2) Host loads setup words, settling word next
// (RL3) Interrupt output runs after interrupt config loaded
// (RL4) Host enables calibration bits last
// (RL5) Results valid after third interrupt
// (RL6) Status read clears interrupt output
// (RL7) Three banks at 0x000, 0x080, 0x0E0
// (RL8) Eight config words per stage, twelve stages
// (RL9) Thirty-six result words per stage
// (RL10) Results update at each sequence end
// (RL11) Host may read result bank
// (RL12) Config and result banks have no reset
// (RL13) Twelve raw words at 0x00B, then ID
// (RL14) Interrupt config, limit, completion status placement
// (RL15) Host avoids invalid address gaps
// (RL16) All registers sixteen bits wide
`timescale 1ns/100ps
`default_nettype none
module cdcrm_device
  import cdcrm_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // Register link
  cdcrm_if.device LNK,
  // Converter side
  input wire logic SEQ_DONE,
  input wire logic [DATA_W-1:0] RESULT_IN,
  input wire logic [DATA_W-1:0] RAW_IN
);
  localparam int CFG_WORDS = NUM_STAGES * CFG_PER_STAGE;
  localparam int RES_WORDS = NUM_STAGES * RES_PER_STAGE;
  logic [DATA_W-1:0] setup_control;
  logic [DATA_W-1:0] cal_setup [4];
  logic [DATA_W-1:0] int_cfg [3];
  logic [DATA_W-1:0] limit_status [2];
  logic [DATA_W-1:0] conversion_completion_status;
  logic [DATA_W-1:0] raw_data [NUM_STAGES];
  logic [DATA_W-1:0] proximity_status;
  logic [DATA_W-1:0] low_power_settling_time;
  logic [DATA_W-1:0] stage_cfg [CFG_WORDS];
  logic [DATA_W-1:0] stage_res [RES_WORDS];
  logic [2:0] int_cfg_loaded;
  logic int_armed;
  logic int_level;
  logic [9:0] res_ptr;
  logic [3:0] raw_ptr;
  logic [DATA_W-1:0] next_rdata;
  logic wr_hit;
  logic rd_hit;

  function automatic logic in_range(input logic [9:0] a, input logic [9:0] lo,
                                    input logic [9:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  assign wr_hit = CE && LNK.req && LNK.wr;
  assign rd_hit = CE && LNK.req && !LNK.wr;

  // (RL16) Sixteen-bit words
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      setup_control <= 16'h0000;
      low_power_settling_time <= 16'h0000;
      for (int i = 0; i < 4; i++)
        cal_setup[i] <= 16'h0000;
      for (int i = 0; i < 3; i++)
        int_cfg[i] <= 16'h0000;
    end
    else if (wr_hit)
    begin
      if (LNK.addr == SETUP_CONTROL)
        setup_control <= LNK.wdata;
      if (LNK.addr == LOW_POWER_SETTLING_TIME)
        low_power_settling_time <= LNK.wdata;
      if (in_range(LNK.addr, CAL_SETUP, CAL_SETUP + 10'h003))
        cal_setup[2'(LNK.addr - CAL_SETUP)] <= LNK.wdata;
      // (RL14) Interrupt config words
      if (in_range(LNK.addr, INT_CFG_FIRST, INT_CFG_LAST))
        int_cfg[2'(LNK.addr - INT_CFG_FIRST)] <= LNK.wdata;
    end
  end

  // (RL12) No reset on config bank
  // (RL8) Stage blocks of eight words
  always_ff @(posedge MCLK)
  begin
    if (wr_hit && in_range(LNK.addr, STAGE_CFG_BASE, STAGE_RES_BASE - 10'h001))
      stage_cfg[7'(LNK.addr - STAGE_CFG_BASE)] <= LNK.wdata;
  end

  // (RL10) Results stream in per sequence
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      res_ptr <= 10'h000;
      raw_ptr <= 4'h0;
    end
    else if (CE && SEQ_DONE)
    begin
      // (RL9) Thirty-six words per stage
      stage_res[9'(res_ptr)] <= RESULT_IN;
      res_ptr <= (res_ptr == 10'(RES_WORDS - 1)) ? 10'h000 : res_ptr + 10'h001;
      // (RL13) Raw data per stage
      raw_data[raw_ptr] <= RAW_IN;
      raw_ptr <= (raw_ptr == 4'(NUM_STAGES - 1)) ? 4'h0 : raw_ptr + 4'h1;
    end
  end

  // Status flags, set wins over read clear
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      conversion_completion_status <= 16'h0000;
      limit_status[0] <= 16'h0000;
      limit_status[1] <= 16'h0000;
      proximity_status <= 16'h0000;
    end
    else if (CE)
    begin
      if (rd_hit && LNK.addr == CONVERSION_COMPLETION_STATUS)
        conversion_completion_status <= 16'h0000;
      if (SEQ_DONE)
        conversion_completion_status <= {4'h0, cal_setup[0][11:0]} | 16'h0001;
      if (rd_hit && LNK.addr == LIMIT_STATUS_0)
        limit_status[0] <= 16'h0000;
      if (rd_hit && LNK.addr == LIMIT_STATUS_1)
        limit_status[1] <= 16'h0000;
      if (SEQ_DONE && (RAW_IN > int_cfg[2]))
        limit_status[0] <= limit_status[0] | 16'h0001;
    end
  end

  // (RL3) Arm after all interrupt config words
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      int_cfg_loaded <= 3'h0;
      int_armed <= 1'b0;
    end
    else if (wr_hit && in_range(LNK.addr, INT_CFG_FIRST, INT_CFG_LAST))
    begin
      int_cfg_loaded[2'(LNK.addr - INT_CFG_FIRST)] <= 1'b1;
      if ((int_cfg_loaded | (3'h1 << 2'(LNK.addr - INT_CFG_FIRST))) == 3'h7)
        int_armed <= 1'b1;
    end
  end

  // (RL6) Read of status clears line
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      int_level <= 1'b0;
    else if (CE)
    begin
      if (rd_hit && in_range(LNK.addr, LIMIT_STATUS_0, CONVERSION_COMPLETION_STATUS))
        int_level <= 1'b0;
      if (int_armed && SEQ_DONE)
        int_level <= 1'b1;
    end
  end

  // (RL7) Bank decode
  always_comb
  begin
    next_rdata = 16'h0000;
    if (LNK.addr == SETUP_CONTROL)
      next_rdata = setup_control;
    else if (in_range(LNK.addr, CAL_SETUP, CAL_SETUP + 10'h003))
      next_rdata = cal_setup[2'(LNK.addr - CAL_SETUP)];
    else if (in_range(LNK.addr, INT_CFG_FIRST, INT_CFG_LAST))
      next_rdata = int_cfg[2'(LNK.addr - INT_CFG_FIRST)];
    else if (in_range(LNK.addr, LIMIT_STATUS_0, LIMIT_STATUS_1))
      next_rdata = limit_status[1'(LNK.addr - LIMIT_STATUS_0)];
    else if (LNK.addr == CONVERSION_COMPLETION_STATUS)
      next_rdata = conversion_completion_status;
    else if (in_range(LNK.addr, RAW_DATA_BASE, PART_IDENTIFICATION - 10'h001))
      next_rdata = raw_data[4'(LNK.addr - RAW_DATA_BASE)];
    else if (LNK.addr == PART_IDENTIFICATION)
      next_rdata = PART_ID_VALUE;
    else if (LNK.addr == PROXIMITY_STATUS)
      next_rdata = proximity_status;
    else if (LNK.addr == LOW_POWER_SETTLING_TIME)
      next_rdata = low_power_settling_time;
    else if (in_range(LNK.addr, STAGE_CFG_BASE, STAGE_RES_BASE - 10'h001))
      next_rdata = stage_cfg[7'(LNK.addr - STAGE_CFG_BASE)];
    // (RL11) Result bank readable
    else if (in_range(LNK.addr, STAGE_RES_BASE, STAGE_RES_END))
      next_rdata = stage_res[9'(LNK.addr - STAGE_RES_BASE)];
  end

  // One-cycle answer, registered
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      LNK.ack <= 1'b0;
      LNK.rdata <= 16'h0000;
    end
    else if (CE)
    begin
      LNK.ack <= LNK.req;
      if (rd_hit)
        LNK.rdata <= next_rdata;
    end
  end

  assign LNK.dev_int = int_level;
endmodule
`default_nettype wire

// ---- rtl/cdcrm_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module cdcrm_host
  import cdcrm_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // Software port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic IRQ,
  // Register link
  cdcrm_if.host LNK
);
  typedef enum logic [1:0] {IDLE, BUSY} cdcrm_state_t;
  cdcrm_state_t state;
  logic [9:0] tgt_addr;
  logic [15:0] tgt_wdata;
  logic [15:0] tgt_rdata;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [1:0] int_count;
  logic int_prev;
  logic int_rise;
  logic data_valid;
  logic cal_written;

  assign int_rise = LNK.dev_int && !int_prev;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      tgt_addr <= 10'h000;
      tgt_wdata <= 16'h0000;
    end
    else if (CE && WR)
    begin
      if (ADDR == H_ADDR)
        tgt_addr <= WDATA[9:0];
      if (ADDR == H_WDATA)
        tgt_wdata <= WDATA;
    end
  end

  // Issue one word transfer; software orders the start-up writes (RL1, RL2)
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      state <= IDLE;
      LNK.req <= 1'b0;
      LNK.wr <= 1'b0;
      LNK.addr <= 10'h000;
      LNK.wdata <= 16'h0000;
      tgt_rdata <= 16'h0000;
    end
    else if (CE)
    begin
      LNK.req <= 1'b0;
      unique case (state)
        IDLE:
        begin
          // (RL15) Gap addresses are dropped
          if (WR && ADDR == H_CTRL && (WDATA[CTRL_WR_BIT] || WDATA[CTRL_RD_BIT]) &&
              !(tgt_addr >= INVALID_GAP_START && tgt_addr < PROXIMITY_STATUS))
          begin
            LNK.req <= 1'b1;
            LNK.wr <= WDATA[CTRL_WR_BIT];
            LNK.addr <= tgt_addr;
            LNK.wdata <= tgt_wdata;
            state <= BUSY;
          end
        end
        BUSY:
        begin
          if (LNK.ack)
          begin
            if (!LNK.wr)
              tgt_rdata <= LNK.rdata;
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Same-clock line, edge detect only
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      int_prev <= 1'b0;
    else if (CE)
      int_prev <= LNK.dev_int;
  end

  // (RL5) Count three interrupts after calibration enable
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      cal_written <= 1'b0;
      int_count <= 2'h0;
      data_valid <= 1'b0;
    end
    else if (CE)
    begin
      // (RL4) Calibration enable write restarts wait
      if (state == IDLE && WR && ADDR == H_CTRL && WDATA[CTRL_WR_BIT] &&
          tgt_addr == CAL_SETUP && (tgt_wdata[11:0] & CAL_EN_MASK) != 12'h000)
      begin
        cal_written <= 1'b1;
        int_count <= 2'h0;
        data_valid <= 1'b0;
      end
      else if (cal_written && int_rise && !data_valid)
      begin
        int_count <= int_count + 2'h1;
        if (int_count == 2'(VALID_INTS - 1))
          data_valid <= 1'b1;
      end
    end
  end

  // Sticky events, set wins over read clear
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      irq_stat <= IRQ_RESET;
    else if (CE)
    begin
      if (RD && ADDR == H_IRQ_STAT)
        irq_stat <= 3'h0;
      if (state == BUSY && LNK.ack)
        irq_stat[IRQ_XFER_BIT] <= 1'b1;
      // (RL3) Device interrupt taken
      if (int_rise)
        irq_stat[IRQ_DEVINT_BIT] <= 1'b1;
      if (cal_written && int_rise && !data_valid && int_count == 2'(VALID_INTS - 1))
        irq_stat[IRQ_VALID_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      irq_mask <= IRQ_RESET;
    else if (CE && WR && ADDR == H_IRQ_MASK)
      irq_mask <= WDATA[2:0];
  end

  // (RL6) Software reads device status to clear line
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      RDATA <= 16'h0000;
      IRQ <= 1'b0;
    end
    else if (CE)
    begin
      IRQ <= |(irq_stat & irq_mask);
      RDATA <= 16'h0000;
      if (RD)
        unique case (ADDR)
          H_ADDR: RDATA <= {6'h00, tgt_addr};
          H_WDATA: RDATA <= tgt_wdata;
          H_RDATA: RDATA <= tgt_rdata;
          H_STATUS: RDATA <= {11'h000, int_count, data_valid, LNK.dev_int, state == BUSY};
          H_IRQ_STAT: RDATA <= {13'h0000, irq_stat};
          H_IRQ_MASK: RDATA <= {13'h0000, irq_mask};
          default: RDATA <= 16'h0000;
        endcase
    end
  end
endmodule
`default_nettype wire

// ---- sim/cdcrm_checker_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module cdcrm_checker
  import cdcrm_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Link
  input wire logic req,
  input wire logic wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic dev_int
);
  logic [3:1] cfg_seen;
  logic rd_req;
  assign rd_req = req && !wr;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  // Interrupt config words written so far
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      cfg_seen <= 3'h0;
    else if (req && wr && addr >= INT_CFG_FIRST && addr <= INT_CFG_LAST)
      cfg_seen[addr[1:0]] <= 1'b1;
  end
  a_ack_follows_req: assert property (req |=> ack)
    else $error("request without ack");
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_id_value: assert property (rd_req && addr == PART_IDENTIFICATION |=> rdata == PART_ID_VALUE)
    else $error("identification value wrong");
  a_unmapped_zero: assert property (rd_req && addr > STAGE_RES_END |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_steady: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  a_int_gated: assert property (dev_int |-> &cfg_seen)
    else $error("interrupt before config loaded");
  a_int_cleared: assert property (rd_req && addr >= LIMIT_STATUS_0
      && addr <= CONVERSION_COMPLETION_STATUS |-> ##[1:2] !dev_int)
    else $error("status read left interrupt high");
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb
  import cdcrm_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] sa = 4'h0;
  logic [15:0] swd = 16'h0000;
  logic swr = 1'b0;
  logic srd = 1'b0;
  logic [15:0] srdat;
  logic irq;
  logic seq = 1'b0;
  logic [15:0] res_in = 16'h0000;
  logic [15:0] raw_in = 16'h0000;
  logic [15:0] lf = 16'hFEA4;
  logic [15:0] q;
  logic [15:0] exp_res [432];
  logic [11:0] cal;
  logic [15:0] thr;
  logic ce = 1'b1;
  int err_count = 0;
  int cmp_count = 0;
  int ptr = 0;
  int idx [4] = '{0, 1, 431, 200};
  cdcrm_if lnk();
  cdcrm_host cdcrm_host_inst(.MCLK(mclk), .RST_N(rst_n), .CE(ce), .ADDR(sa), .WDATA(swd),
    .WR(swr), .RD(srd), .RDATA(srdat), .IRQ(irq), .LNK(lnk.host));
  cdcrm_device cdcrm_device_inst(.MCLK(mclk), .RST_N(rst_n), .CE(ce), .LNK(lnk.device),
    .SEQ_DONE(seq), .RESULT_IN(res_in), .RAW_IN(raw_in));
  cdcrm_checker cdcrm_checker_inst(.MCLK(mclk), .RST_N(rst_n), .req(lnk.req), .wr(lnk.wr),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata), .dev_int(lnk.dev_int));
  initial
    forever #5 mclk = ~mclk;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Completion word carries the enabled stages plus bit 0
  function automatic logic [15:0] comp_exp(input logic [11:0] c);
    return {4'h0, c | 12'h001};
  endfunction
  task chk(input string nm, input logic [15:0] sn, input logic [15:0] ex);
    cmp_count++;
    if (sn !== ex)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task sw_w(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    sa <= a;
    swd <= d;
    swr <= 1'b1;
    @(posedge mclk);
    swr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task sw_r(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    sa <= a;
    srd <= 1'b1;
    @(posedge mclk);
    srd <= 1'b0;
    #1 d = srdat;
  endtask
  task lx(input logic w, input logic [9:0] a, input logic [15:0] d, output logic [15:0] r);
    int i;
    sw_w(H_ADDR, {6'h00, a});
    sw_w(H_WDATA, d);
    sw_w(H_CTRL, w ? 16'h0001 : 16'h0002);
    repeat (2) @(posedge mclk);
    r = 16'h0001;
    for (i = 0; i < 20 && r[0] !== 1'b0; i++)
      sw_r(H_STATUS, r);
    if (i == 20)
      chk("busy", 16'h0001, 16'h0000);
    r = 16'h0000;
    if (!w)
      sw_r(H_RDATA, r);
  endtask
  task pulse;
    @(posedge mclk);
    lf = nx(lf);
    seq <= 1'b1;
    res_in <= lf;
    raw_in <= ~lf;
    exp_res[ptr] = lf;
    ptr = (ptr + 1) % 432;
    @(posedge mclk);
    seq <= 1'b0;
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    sw_w(H_IRQ_MASK, 16'h0000);
    sw_r(H_IRQ_STAT, q);
    chk("irq_stat", q, {13'h0000, IRQ_RESET});
    for (int s = 0; s < 12; s++)
    begin
      lf = nx(lf);
      lx(1'b1, STAGE_CFG_BASE + 10'(8 * s + s % 8), lf, q);
      lx(1'b0, STAGE_CFG_BASE + 10'(8 * s + s % 8), 16'h0000, q);
      chk("stage_cfg", q, lf);
    end
    lx(1'b1, SETUP_CONTROL, 16'h0800, q);
    lx(1'b1, CAL_SETUP, 16'h0000, q);
    for (int k = 2; k < 5; k++)
    begin
      lf = nx(lf);
      lx(1'b1, 10'(k), lf, q);
    end
    lf = nx(lf);
    lx(1'b1, LOW_POWER_SETTLING_TIME, lf, q);
    lx(1'b0, LOW_POWER_SETTLING_TIME, 16'h0000, q);
    chk("settling", q, lf);
    lx(1'b0, SETUP_CONTROL, 16'h0000, q);
    chk("setup", q, 16'h0800);
    lx(1'b1, PART_IDENTIFICATION, ~PART_ID_VALUE, q);
    lx(1'b0, PART_IDENTIFICATION, 16'h0000, q);
    chk("part_id", q, PART_ID_VALUE);
    lx(1'b0, 10'h300, 16'h0000, q);
    chk("unmapped", q, 16'h0000);
    sw_r(H_IRQ_STAT, q);
    chk("xfer_stat", {13'h0000, q[2:0]}, 16'h0001);
    chk("irq_masked", {15'h0000, irq}, 16'h0000);
    sw_w(H_IRQ_MASK, 16'h0001);
    lx(1'b0, PART_IDENTIFICATION, 16'h0000, q);
    repeat (3) @(posedge mclk);
    chk("irq_on", {15'h0000, irq}, 16'h0001);
    sw_r(H_IRQ_STAT, q);
    repeat (2) @(posedge mclk);
    chk("irq_off", {15'h0000, irq}, 16'h0000);
    lx(1'b0, INVALID_GAP_START, 16'h0000, q);
    sw_r(H_IRQ_STAT, q);
    chk("gap_drop", {13'h0000, q[2:0]}, 16'h0000);
    sw_w(H_IRQ_MASK, 16'h0004);
    // Enough sequences to wrap the result bank
    repeat (433) pulse;
    repeat (4) @(posedge mclk);
    chk("int_early", {15'h0000, lnk.dev_int}, 16'h0000);
    for (int j = 0; j < 4; j++)
    begin
      lx(1'b0, STAGE_RES_BASE + 10'(idx[j]), 16'h0000, q);
      chk("result", q, exp_res[idx[j]]);
    end
    lx(1'b0, RAW_DATA_BASE, 16'h0000, q);
    chk("raw_first", q, ~exp_res[0]);
    lx(1'b0, RAW_DATA_BASE + 10'h00B, 16'h0000, q);
    chk("raw_last", q, ~exp_res[431]);
    for (int k = 5; k < 8; k++)
    begin
      lf = nx(lf);
      lx(1'b1, 10'(k), lf, q);
    end
    thr = lf;
    pulse;
    repeat (3) @(posedge mclk);
    chk("int_on", {15'h0000, lnk.dev_int}, 16'h0001);
    lx(1'b0, CONVERSION_COMPLETION_STATUS, 16'h0000, q);
    chk("complete", {4'h0, q[11:0]}, comp_exp(12'h000));
    chk("int_clr", {15'h0000, lnk.dev_int}, 16'h0000);
    lf = nx(lf);
    cal = lf[11:0] | 12'h001;
    lx(1'b1, CAL_SETUP, {4'h0, cal}, q);
    for (int k = 1; k < 4; k++)
    begin
      pulse;
      repeat (6) @(posedge mclk);
      chk("int_seq", {15'h0000, lnk.dev_int}, 16'h0001);
      lx(1'b0, LIMIT_STATUS_0, 16'h0000, q);
      if (k > 1)
        chk("limit", {15'h0000, q[0]}, {15'h0000, 1'(raw_in > thr)});
      sw_r(H_STATUS, q);
      chk("valid", {15'h0000, q[2]}, {15'h0000, 1'(k == 3)});
    end
    chk("irq_valid", {15'h0000, irq}, 16'h0001);
    // Frozen clock enable: mask write and sequence both ignored
    ce <= 1'b0;
    sw_w(H_IRQ_MASK, 16'h0000);
    pulse;
    @(posedge mclk);
    ce <= 1'b1;
    chk("ce_hold", {14'h0000, irq, lnk.dev_int}, 16'h0002);
    lx(1'b0, CONVERSION_COMPLETION_STATUS, 16'h0000, q);
    chk("complete_cal", {4'h0, q[11:0]}, comp_exp(cal));
    wrap_up;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
